// File: bss_pkg.sv
package bss_pkg;
	// wishbone register map (byte addresses)
	localparam logic [7:0] BSS_CTRL_OFS = 8'h00;
	localparam logic [7:0] BSS_STATUS_OFS = 8'h04;
	// control register fields
	localparam int BSS_REQ_BIT = 0;
	localparam int BSS_HIZ_BIT = 1;
	localparam int BSS_PINEN_BIT = 2;
	localparam int BSS_POL_BIT = 3;
	localparam int BSS_AUXDIS_BIT = 6;
	localparam logic [7:0] BSS_CTRL_RST = 8'h00;
	localparam logic [7:0] BSS_CTRL_MASK = 8'h4F;
	// status register fields
	localparam int BSS_FAULT_LSB = 0;
	localparam int BSS_RUN_BIT = 3;
	localparam int BSS_STATE_LSB = 4;
	localparam int BSS_PIN_BIT = 7;
	// fault codes; the timer code is reported in any state, the others while boosting
	localparam logic [2:0] BSS_FC_NONE = 3'h0;
	localparam logic [2:0] BSS_FC_OVP = 3'h1;
	localparam logic [2:0] BSS_FC_START = 3'h2;
	localparam logic [2:0] BSS_FC_UVLO = 3'h3;
	localparam logic [2:0] BSS_FC_THERM = 3'h5;
	localparam logic [2:0] BSS_FC_TIMER = 3'h6;
	// timing
	localparam int BSS_CLK_PERIOD_NS = 10;
	localparam int BSS_T_LIN_US = 560;
	localparam int BSS_T_SS1_US = 128;
	localparam int BSS_T_SS2_US = 384;
	localparam int BSS_T_ILIM_US = 50;
	localparam int BSS_T_STAT_US = 128;
	localparam real BSS_T_RESTART_MS = 5.2;
	localparam real BSS_T_RETRY_MS = 5.0;
	localparam int BSS_LIN_CYC = BSS_T_LIN_US * 1000 / BSS_CLK_PERIOD_NS;
	localparam int BSS_SS1_CYC = BSS_T_SS1_US * 1000 / BSS_CLK_PERIOD_NS;
	localparam int BSS_SS2_CYC = BSS_T_SS2_US * 1000 / BSS_CLK_PERIOD_NS;
	localparam int BSS_ILIM_CYC = BSS_T_ILIM_US * 1000 / BSS_CLK_PERIOD_NS;
	localparam int BSS_STAT_CYC = BSS_T_STAT_US * 1000 / BSS_CLK_PERIOD_NS;
	localparam int BSS_RESTART_CYC =
		int'($ceil(BSS_T_RESTART_MS * 1.0e6 / BSS_CLK_PERIOD_NS));
	localparam int BSS_RETRY_CYC =
		int'($ceil(BSS_T_RETRY_MS * 1.0e6 / BSS_CLK_PERIOD_NS));
	// sequencer states
	typedef enum logic [2:0] {
		BSS_SHDN = 3'b000,
		BSS_LIN = 3'b001,
		BSS_SS1 = 3'b010,
		BSS_SS2 = 3'b011,
		BSS_RUN = 3'b100,
		BSS_WAIT = 3'b101
	} bss_state_e;
endpackage : bss_pkg

// File: bss_sequencer.sv
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module bss_sequencer
	import bss_pkg::*;
#(
	parameter int unsigned LIN_CYC = BSS_LIN_CYC,
	parameter int unsigned SS1_CYC = BSS_SS1_CYC,
	parameter int unsigned SS2_CYC = BSS_SS2_CYC,
	parameter int unsigned ILIM_CYC = BSS_ILIM_CYC,
	parameter int unsigned STAT_CYC = BSS_STAT_CYC,
	parameter int unsigned RESTART_CYC = BSS_RESTART_CYC,
	parameter int unsigned RETRY_CYC = BSS_RETRY_CYC
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// analog comparators and pins (asynchronous)
	input wire logic boost_pin,
	input wire logic bat_above_uvlo,
	input wire logic mid_above_bat_ofs,
	input wire logic mid_above_bat,
	input wire logic bus_in_band,
	input wire logic bus_above_95,
	input wire logic bus_above_boost,
	input wire logic bus_above_reg,
	input wire logic min_off_done,
	input wire logic cur_limit_hit,
	input wire logic bus_ovp,
	input wire logic therm_sd,
	// on-chip safety timer expiry, same clock
	input wire logic timer_fault,
	// power stage controls
	output logic lin_src_en,
	output logic pass_sw_en,
	output logic stage_hiz,
	output logic switch_en,
	output logic ilim_full,
	output logic loop_closed,
	output logic pfm_mode,
	output logic long_ton,
	output logic aux_regulator_output,
	// status pin, open drain
	output logic stat_o,
	output logic stat_oe
);
	localparam int NIN = 12;

	// synchronisers
	logic [NIN-1:0] raw_in;
	logic [NIN-1:0] s1_r;
	logic [NIN-1:0] s2_r;
	logic [NIN-1:0] s3_r;
	logic [NIN-1:0] q_r;

	assign raw_in = {therm_sd, bus_ovp, cur_limit_hit, min_off_done,
		bus_above_reg, bus_above_boost, bus_above_95, bus_in_band,
		mid_above_bat, mid_above_bat_ofs, bat_above_uvlo, boost_pin};

	genvar gi;
	generate
		for (gi = 0; gi < NIN; gi++) begin : g_sync
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					s1_r[gi] <= 1'b0;
					s2_r[gi] <= 1'b0;
					s3_r[gi] <= 1'b0;
					q_r[gi] <= 1'b0;
				end else begin
					s1_r[gi] <= raw_in[gi];
					s2_r[gi] <= s1_r[gi];
					s3_r[gi] <= s2_r[gi];
					// accept a change once two stages agree
					if (s2_r[gi] == s3_r[gi]) begin
						q_r[gi] <= s3_r[gi];
					end
				end
			end
		end
	endgenerate

	logic pin_q, uvlo_ok, mid_ofs_ok, mid_gt_bat, band_ok, above95;
	logic above_boost, above_reg, off_done, ilim_q, ovp_q, therm_q;
	logic off_done_d;
	assign {therm_q, ovp_q, ilim_q, off_done, above_reg, above_boost,
		above95, band_ok, mid_gt_bat, mid_ofs_ok, uvlo_ok, pin_q} = q_r;

	// registers
	logic [7:0] ctrl_r;
	logic [2:0] fault_r;
	bss_state_e state_r;
	logic [19:0] tmr_r;
	logic [12:0] ilim_cnt_r;
	logic [13:0] stat_cnt_r;
	logic retried_r;
	logic pfm_r;

	logic req, hiz, pin_en, pol, aux_dis, pin_active, boost_en;
	assign req = ctrl_r[BSS_REQ_BIT];
	assign hiz = ctrl_r[BSS_HIZ_BIT];
	assign pin_en = ctrl_r[BSS_PINEN_BIT];
	assign pol = ctrl_r[BSS_POL_BIT];
	assign aux_dis = ctrl_r[BSS_AUXDIS_BIT];
	assign pin_active = pol ? pin_q : ~pin_q;
	// the pin path ignores high impedance, the request bit does not
	assign boost_en = (pin_en & pin_active) | (req & ~hiz);

	logic active;
	assign active = (state_r == BSS_LIN) || (state_r == BSS_SS1) ||
		(state_r == BSS_SS2) || (state_r == BSS_RUN);

	// fault detection, first match wins
	logic fault_ev;
	logic [2:0] fault_code;
	always_comb begin
		fault_ev = 1'b0;
		fault_code = BSS_FC_NONE;
		if (timer_fault) begin
			fault_ev = 1'b1;
			fault_code = BSS_FC_TIMER;
		end else if (active) begin
			if (ovp_q) begin
				fault_ev = 1'b1;
				fault_code = BSS_FC_OVP;
			end else if (!uvlo_ok) begin
				fault_ev = 1'b1;
				fault_code = BSS_FC_UVLO;
			end else if (therm_q) begin
				fault_ev = 1'b1;
				fault_code = BSS_FC_THERM;
			end else if (state_r == BSS_LIN && !mid_ofs_ok &&
					tmr_r >= 20'(LIN_CYC - 1)) begin
				fault_ev = 1'b1;
				fault_code = BSS_FC_START;
			end else if (state_r == BSS_SS2 && !above95 &&
					tmr_r >= 20'(SS2_CYC - 1)) begin
				fault_ev = 1'b1;
				fault_code = BSS_FC_START;
			end else if (state_r == BSS_RUN &&
					ilim_cnt_r >= 13'(ILIM_CYC)) begin
				fault_ev = 1'b1;
				fault_code = BSS_FC_START;
			end
		end
	end

	// bus decode
	logic wb_req, wr_ctrl, rd_status;
	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] &
		(wb_adr_i == BSS_CTRL_OFS);
	assign rd_status = wb_req & ~wb_we_i & (wb_adr_i == BSS_STATUS_OFS);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_req;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wb_dat_o <= 32'h0000_0000;
		end else if (wb_req && !wb_we_i) begin
			wb_dat_o <= 32'h0000_0000;
			if (wb_adr_i == BSS_CTRL_OFS) begin
				wb_dat_o[7:0] <= ctrl_r;
			end else if (wb_adr_i == BSS_STATUS_OFS) begin
				wb_dat_o[BSS_FAULT_LSB +: 3] <= fault_r;
				wb_dat_o[BSS_RUN_BIT] <= (state_r == BSS_RUN);
				wb_dat_o[BSS_STATE_LSB +: 3] <= state_r;
				wb_dat_o[BSS_PIN_BIT] <= pin_q;
			end
		end
	end

	// control register; hardware clearing overrides a write in the same cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_r <= BSS_CTRL_RST;
		end else if (timer_fault) begin
			ctrl_r <= BSS_CTRL_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= wb_dat_i[7:0] & BSS_CTRL_MASK;
			end
			if (fault_ev || (active && !boost_en)) begin
				ctrl_r[BSS_REQ_BIT] <= 1'b0;
			end
		end
	end

	// fault code: held until status is read, a new fault wins over the clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fault_r <= BSS_FC_NONE;
		end else if (fault_ev) begin
			fault_r <= fault_code;
		end else if (rd_status) begin
			fault_r <= BSS_FC_NONE;
		end
	end

	// sequencer and its single interval timer
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= BSS_SHDN;
			tmr_r <= 20'h00000;
			retried_r <= 1'b0;
		end else if (fault_ev) begin
			tmr_r <= 20'h00000;
			if (!timer_fault && pin_en && pin_active) begin
				state_r <= BSS_WAIT;
			end else begin
				state_r <= BSS_SHDN;
				retried_r <= 1'b0;
			end
		end else begin
			tmr_r <= tmr_r + 20'h00001;
			unique case (state_r)
				BSS_SHDN: begin
					retried_r <= 1'b0;
					tmr_r <= 20'h00000;
					if (boost_en && uvlo_ok) begin
						state_r <= BSS_LIN;
					end
				end
				BSS_LIN: begin
					if (!boost_en) begin
						state_r <= BSS_SHDN;
					end else if (mid_ofs_ok) begin
						state_r <= BSS_SS1;
						tmr_r <= 20'h00000;
					end
				end
				BSS_SS1: begin
					if (!boost_en) begin
						state_r <= BSS_SHDN;
					end else if (band_ok) begin
						state_r <= BSS_RUN;
					end else if (!above95 &&
							tmr_r >= 20'(SS1_CYC - 1)) begin
						state_r <= BSS_SS2;
						tmr_r <= 20'h00000;
					end
				end
				BSS_SS2: begin
					if (!boost_en) begin
						state_r <= BSS_SHDN;
					end else if (band_ok) begin
						state_r <= BSS_RUN;
					end
				end
				BSS_RUN: begin
					retried_r <= 1'b0;
					if (!boost_en) begin
						state_r <= BSS_SHDN;
					end
				end
				BSS_WAIT: begin
					// first wait is the restart delay, later ones the retry period
					if (!(pin_en && pin_active)) begin
						state_r <= BSS_SHDN;
					end else if (tmr_r >= (retried_r ?
							20'(RETRY_CYC - 1) : 20'(RESTART_CYC - 1))) begin
						state_r <= BSS_LIN;
						tmr_r <= 20'h00000;
						retried_r <= 1'b1;
					end
				end
				default: begin
					state_r <= BSS_SHDN;
				end
			endcase
		end
	end

	// sustained current limit in run
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ilim_cnt_r <= 13'h0000;
		end else if (state_r == BSS_RUN && ilim_q) begin
			if (ilim_cnt_r < 13'(ILIM_CYC)) begin
				ilim_cnt_r <= ilim_cnt_r + 13'h0001;
			end
		end else begin
			ilim_cnt_r <= 13'h0000;
		end
	end

	// pfm decided at the end of each minimum off-time
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			off_done_d <= 1'b0;
			pfm_r <= 1'b0;
		end else begin
			off_done_d <= off_done;
			if (state_r != BSS_RUN) begin
				pfm_r <= 1'b0;
			end else if (off_done && !off_done_d) begin
				pfm_r <= above_boost;
			end
		end
	end

	// status pin pulse; a new fault restarts it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stat_cnt_r <= 14'h0000;
		end else if (fault_ev) begin
			stat_cnt_r <= 14'(STAT_CYC);
		end else if (stat_cnt_r != 14'h0000) begin
			stat_cnt_r <= stat_cnt_r - 14'h0001;
		end
	end

	// output stage
	logic switching;
	assign switching = (state_r == BSS_SS1) || (state_r == BSS_SS2) ||
		(state_r == BSS_RUN);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			lin_src_en <= 1'b0;
			pass_sw_en <= 1'b0;
			stage_hiz <= 1'b1;
			switch_en <= 1'b0;
			ilim_full <= 1'b0;
			loop_closed <= 1'b0;
			pfm_mode <= 1'b0;
			long_ton <= 1'b0;
			aux_regulator_output <= 1'b0;
		end else begin
			lin_src_en <= (state_r == BSS_LIN) && !fault_ev;
			// pass switches only close once switching starts
			pass_sw_en <= switching && !fault_ev;
			stage_hiz <= !(active && !fault_ev);
			switch_en <= switching && !fault_ev &&
				!(state_r == BSS_RUN && above_reg) &&
				!(pfm_r && above_boost);
			// half limit only in the first soft-start window
			ilim_full <= (state_r == BSS_SS2) ||
				(state_r == BSS_RUN);
			loop_closed <= (state_r == BSS_RUN);
			pfm_mode <= pfm_r;
			long_ton <= pfm_r;
			aux_regulator_output <= !aux_dis && mid_gt_bat &&
				!active && !hiz;
		end
	end

	assign stat_o = 1'b0;
	assign stat_oe = (stat_cnt_r != 14'h0000);
endmodule : bss_sequencer

// File: bss_sequencer_chk.sv
`timescale 1ns/1ps
module bss_sequencer_chk #(
	parameter int unsigned LIN_CYC = 40,
	parameter int unsigned STAT_CYC = 8
) (
	// clock, reset and bus handshake
	input wire logic clk, rst, wb_cyc_i, wb_stb_i, wb_ack_o,
	// comparators seen by the run loop
	input wire logic bus_above_reg, bus_above_boost,
	// power stage controls and status pin
	input wire logic stage_hiz, pass_sw_en, lin_src_en, ilim_full,
	input wire logic loop_closed, pfm_mode, long_ton, switch_en,
	input wire logic aux_regulator_output, stat_oe
);
	logic [15:0] stat_cnt_r;
	logic [19:0] lin_cnt_r;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// counters let long pulse widths be checked without deep repetition
	always_ff @(posedge clk or posedge rst) begin
		if (rst) stat_cnt_r <= 16'h0000;
		else stat_cnt_r <= stat_oe ? stat_cnt_r + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) lin_cnt_r <= 20'h00000;
		else lin_cnt_r <= lin_src_en ? lin_cnt_r + 20'h00001 : 20'h00000;
	end
	property p_ack_next; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack missing");
	property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
	property p_shut_open; stage_hiz |-> !pass_sw_en && !switch_en; endproperty
	a_shut_open: assert property (p_shut_open) else $error("switch on");
	property p_ss_half; $rose(pass_sw_en) |-> !ilim_full && !loop_closed; endproperty
	a_ss_half: assert property (p_ss_half) else $error("soft limit");
	property p_run_full; loop_closed |-> ilim_full; endproperty
	a_run_full: assert property (p_run_full) else $error("run limit");
	property p_pfm_long; pfm_mode |-> long_ton; endproperty
	a_pfm_long: assert property (p_pfm_long) else $error("pfm on-time");
	property p_reg_off; (loop_closed && bus_above_reg)[*6] |-> !switch_en; endproperty
	a_reg_off: assert property (p_reg_off) else $error("switch high");
	property p_pfm_inh; (pfm_mode && bus_above_boost)[*6] |-> !switch_en; endproperty
	a_pfm_inh: assert property (p_pfm_inh) else $error("pfm pulse");
	property p_aux_run;
		loop_closed && $past(loop_closed) |-> !aux_regulator_output;
	endproperty
	a_aux_run: assert property (p_aux_run) else $error("aux on");
	property p_stat_len; $fell(stat_oe) |-> stat_cnt_r == STAT_CYC; endproperty
	a_stat_len: assert property (p_stat_len) else $error("stat width");
	property p_lin_lim; lin_cnt_r <= LIN_CYC + 2; endproperty
	a_lin_lim: assert property (p_lin_lim) else $error("precharge long");
	c_run: cover property ($rose(loop_closed));
	c_pfm: cover property ($rose(pfm_mode));
	c_fault: cover property ($rose(stat_oe));
endmodule : bss_sequencer_chk

// File: bss_stage_model.sv
`timescale 1ns/1ps
module bss_stage_model (
	// clock, reset and stage controls
	input wire logic clk, rst, lin_src_en, pass_sw_en,
	// scenario knobs
	input wire logic mid_stuck, bus_stuck, bus_high,
	// comparator levels
	output logic mid_above_bat_ofs, mid_above_bat, bus_in_band, bus_above_95,
	output logic bus_above_boost, bus_above_reg, min_off_done
);
	logic [4:0] mid_r, bus_r;
	logic [1:0] off_r;
	// nodes discharge once the stage lets go of them
	always_ff @(posedge clk or posedge rst) begin
		if (rst || (!lin_src_en && !pass_sw_en)) mid_r <= 5'h00;
		else if (lin_src_en && !mid_stuck && mid_r < 5'h1F) mid_r <= mid_r + 5'h01;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst || !pass_sw_en) bus_r <= 5'h00;
		else if (!bus_stuck && bus_r < 5'h1F) bus_r <= bus_r + 5'h01;
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) off_r <= 2'h0;
		else off_r <= off_r + 2'h1;
	end
	assign mid_above_bat_ofs = mid_r >= 5'h06;
	assign mid_above_bat = mid_r >= 5'h06;
	assign bus_above_95 = bus_r >= 5'h06;
	assign bus_in_band = bus_r >= 5'h08;
	assign bus_above_boost = bus_high;
	assign bus_above_reg = bus_high;
	assign min_off_done = off_r[1];
endmodule : bss_stage_model

// File: bss_sequencer_tb.sv
`timescale 1ns/1ps
module bss_sequencer_tb;
	import bss_pkg::*;
	logic clk = 1'b0, rst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
	logic wb_we_i = 1'b0, wb_ack_o, boost_pin = 1'b0, bat_above_uvlo = 1'b1;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
	logic cur_limit_hit = 1'b0, bus_ovp = 1'b0, therm_sd = 1'b0;
	logic timer_fault = 1'b0, mid_stuck = 1'b0, bus_stuck = 1'b0, bus_high = 1'b0;
	logic mid_above_bat_ofs, mid_above_bat, bus_in_band, bus_above_95, long_ton;
	logic bus_above_boost, bus_above_reg, min_off_done, lin_src_en, pass_sw_en;
	logic stage_hiz, switch_en, ilim_full, loop_closed, pfm_mode, stat_o;
	logic aux_regulator_output, stat_oe;
	int miscompares = 0, num_checks = 0, cyc_cnt = 0, n;
	logic [2:0] codes [4] = '{3'h1, 3'h3, 3'h5, 3'h2};
	always #5 clk = ~clk;
	// first soft-start window and current-limit time run at full length
	bss_sequencer #(.LIN_CYC(40), .SS2_CYC(30), .STAT_CYC(8),
		.RESTART_CYC(100), .RETRY_CYC(80)) dut (.clk, .rst,
		.wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
		.wb_ack_o, .boost_pin, .bat_above_uvlo, .mid_above_bat_ofs, .mid_above_bat,
		.bus_in_band, .bus_above_95, .bus_above_boost, .bus_above_reg,
		.min_off_done, .cur_limit_hit, .bus_ovp, .therm_sd, .timer_fault,
		.lin_src_en, .pass_sw_en, .stage_hiz, .switch_en, .ilim_full, .loop_closed,
		.pfm_mode, .long_ton, .aux_regulator_output, .stat_o, .stat_oe);
	bss_stage_model stage (.clk, .rst, .lin_src_en, .pass_sw_en, .mid_stuck,
		.bus_stuck, .bus_high, .mid_above_bat_ofs, .mid_above_bat, .bus_in_band,
		.bus_above_95, .bus_above_boost, .bus_above_reg, .min_off_done);
	task chk(input string what, input logic [31:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= a;
		wb_dat_i <= d;
		@(posedge clk);
		while (wb_ack_o !== 1'b1) @(posedge clk);
		rd = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk);
	endtask : wb
	task wait_fault(input logic [2:0] code);
		for (n = 0; stat_oe !== 1'b1 && n < 20000; n++) @(posedge clk);
		wb(1'b0, BSS_STATUS_OFS, 32'h0);
		chk("fault code", rd & 32'h7, {29'h0, code});
		wb(1'b0, BSS_STATUS_OFS, 32'h0);
		chk("cleared code", rd & 32'h7, 32'h0);
		wb(1'b0, BSS_CTRL_OFS, 32'h0);
		chk("request bit", rd & 32'h1, 32'h0);
		repeat (20) @(posedge clk);
	endtask : wait_fault
	task start_run;
		wb(1'b1, BSS_CTRL_OFS, 32'h01);
		for (n = 0; loop_closed !== 1'b1 && n < 300; n++) @(posedge clk);
	endtask : start_run
	task gap(input int lo);
		for (n = 0; stat_oe !== 1'b1 && n < 400; n++) @(posedge clk);
		// count from one fault pulse's start to the next one's
		for (n = 0; stat_oe !== 1'b0 && n < 400; n++) @(posedge clk);
		while (stat_oe !== 1'b1 && n < 400) begin
			n++;
			@(posedge clk);
		end
		// one extra cycle: the retried precharge state flags the fault
		chk("restart gap", 32'(n), 32'(lo + 1));
	endtask : gap
	task t_regs;
		wb(1'b0, BSS_CTRL_OFS, 32'h0);
		chk("ctrl reset", rd, 32'h0);
		wb(1'b1, BSS_CTRL_OFS, 32'hFF);
		wb(1'b0, BSS_CTRL_OFS, 32'h0);
		chk("ctrl mask", rd, 32'h4F);
		wb_sel_i <= 4'hE;
		wb(1'b1, BSS_CTRL_OFS, 32'h0);
		wb_sel_i <= 4'hF;
		wb(1'b0, BSS_CTRL_OFS, 32'h0);
		chk("ctrl sel", rd, 32'h4F);
		wb(1'b1, BSS_CTRL_OFS, 32'h0);
		wb(1'b0, 8'h08, 32'h0);
		chk("unmapped", rd, 32'h0);
		$display("regs done");
	endtask : t_regs
	task t_startup;
		wb(1'b1, BSS_CTRL_OFS, 32'h01);
		for (n = 0; pass_sw_en !== 1'b1 && n < 300; n++) @(posedge clk);
		chk("soft limit", 32'(ilim_full), 32'h0);
		start_run;
		chk("run limit", 32'(ilim_full), 32'h1);
		wb(1'b0, BSS_STATUS_OFS, 32'h0);
		chk("run status", rd, 32'h48);
		chk("aux in run", 32'(aux_regulator_output), 32'h0);
		bus_high <= 1'b1;
		repeat (12) @(posedge clk);
		chk("pfm", 32'(pfm_mode && long_ton), 32'h1);
		chk("switch off", 32'(switch_en), 32'h0);
		bus_high <= 1'b0;
		wb(1'b1, BSS_CTRL_OFS, 32'h03);
		repeat (8) @(posedge clk);
		chk("stage hiz", 32'(stage_hiz && !pass_sw_en), 32'h1);
		wb(1'b0, BSS_CTRL_OFS, 32'h0);
		chk("hiz override", rd, 32'h02);
		wb(1'b1, BSS_CTRL_OFS, 32'h0);
		$display("startup done");
	endtask : t_startup
	task t_faults;
		mid_stuck <= 1'b1;
		wb(1'b1, BSS_CTRL_OFS, 32'h01);
		wait_fault(3'h2);
		mid_stuck <= 1'b0;
		bus_stuck <= 1'b1;
		wb(1'b1, BSS_CTRL_OFS, 32'h01);
		wait_fault(3'h2);
		bus_stuck <= 1'b0;
		for (int i = 0; i < 4; i++) begin
			start_run;
			bus_ovp <= i == 0;
			bat_above_uvlo <= i != 1;
			therm_sd <= i == 2;
			cur_limit_hit <= i == 3;
			wait_fault(codes[i]);
			bus_ovp <= 1'b0;
			bat_above_uvlo <= 1'b1;
			therm_sd <= 1'b0;
			cur_limit_hit <= 1'b0;
			repeat (10) @(posedge clk);
		end
		wb(1'b1, BSS_CTRL_OFS, 32'h41);
		timer_fault <= 1'b1;
		@(posedge clk);
		timer_fault <= 1'b0;
		wait_fault(BSS_FC_TIMER);
		chk("ctrl after timer", rd, 32'h0);
		$display("faults done");
	endtask : t_faults
	task t_restart;
		wb(1'b1, BSS_CTRL_OFS, 32'h0C);
		boost_pin <= 1'b1;
		bus_ovp <= 1'b1;
		gap(100);
		gap(80);
		bus_ovp <= 1'b0;
		wb(1'b1, BSS_CTRL_OFS, 32'h00);
		repeat (10) @(posedge clk);
		wb(1'b0, BSS_STATUS_OFS, 32'h0);
		chk("state after disable", rd & 32'h70, 32'h0);
		$display("restart done");
	endtask : t_restart
	task give_verdict;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		t_regs;
		t_startup;
		t_faults;
		t_restart;
		give_verdict;
	end
	// ceiling well above the roughly twenty thousand cycles the tests need
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 60000) begin
			miscompares++;
			give_verdict;
		end
	end
endmodule : bss_sequencer_tb
bind bss_sequencer bss_sequencer_chk #(.LIN_CYC(LIN_CYC), .STAT_CYC(STAT_CYC))
	u_chk (.clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .bus_above_reg,
	.bus_above_boost, .stage_hiz, .pass_sw_en, .lin_src_en, .ilim_full,
	.loop_closed, .pfm_mode, .long_ton, .switch_en, .aux_regulator_output,
	.stat_oe);
